// *** ptd_host_model.sv ***
// Host model that programs and reads the detector registers.
// Assumes the bench calls wr and rd; strobes last one edge.
`timescale 1ns/1ps
`default_nettype none
module ptd_host_model (
	input wire logic clk,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData
);
	initial {regWrite, regRead, regAddr, regWrData} = '0;
	// One byte write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		{regWrite, regAddr, regWrData} = {1'b1, a, d};
		@(posedge clk) #1;
		regWrite = 1'b0;
	endtask : wr
	// One byte read, data taken after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		{regRead, regAddr} = {1'b1, a};
		@(posedge clk) #1;
		regRead = 1'b0;
		d = regRdData;
	endtask : rd
endmodule : ptd_host_model
`default_nettype wire

// *** ptd_pkg.sv ***
// Types shared by the pulse timing detector and its surroundings.
// Assumes acceleration arrives as signed 8-bit codes of 0.063 g.
`default_nettype none
package ptd_pkg;

	// Per-axis acceleration, index 0 = X, 1 = Y, 2 = Z
	typedef struct packed {
		logic [2:0][7:0] axis;
	} ptd_accel_s;

	// Oversampling mode codes
	typedef enum logic [1:0] {
		OS_NORMAL = 2'h0,
		OS_LOWNOISE = 2'h1,
		OS_HIRES = 2'h2,
		OS_LOWPOWER = 2'h3
	} ptd_osmode_e;

	// Loose control bits held in other registers of the device
	typedef struct packed {
		logic [2:0] dataRate;
		ptd_osmode_e osMode;
		logic lowNoise;
		logic pulseLowpassEnable;
		logic singleEnable;
		logic doubleEnable;
	} ptd_mode_s;

	// Detector states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FIRST = 3'b001,
		ST_LATENCY = 3'b011,
		ST_WINDOW = 3'b010,
		ST_SECOND = 3'b110,
		ST_RELEASE = 3'b100
	} ptd_state_e;

endpackage : ptd_pkg
`default_nettype wire

// *** ptd_pulse_timing.sv ***
// Pulse (tap) timing detector: thresholds, time limit, latency, window.
// Assumes accel, mode and register strobes come from logic on clk.
//
// Behaviour
// - Each of X, Y and Z keeps its own 7-bit unsigned start threshold.
// - Threshold codes 1 to 127 are 0.063 g steps on a fixed 8 g scale.
// - With low noise on, the effective threshold never exceeds 4 g.
// - Detection on an axis starts when its magnitude exceeds its threshold.
// - A pulse counts only if it falls back below within the time limit.
// - The longest time limit is 255 steps of the active step size.
// - With the pulse filter on, time-limit steps follow the filtered table.
// - With the pulse filter off, time-limit steps follow the halved table.
// - After a first pulse a latency interval ignores all further pulses.
// - The longest latency is 255 steps of the active latency step.
// - With the pulse filter on, latency steps are twice the time-limit steps.
// - With the pulse filter off, latency steps are the halved table doubled.
// - A second pulse must start inside the window that follows the latency.
// - Reading the event source register clears the event and its interrupt unless a new event arrives in that cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ptd_regs.svh"

module ptd_pulse_timing
	import ptd_pkg::*;
#(
	parameter int BASE_CYCLES = `PTD_BASE_STEP_NS / `PTD_CLK_NS
)
(
	input wire logic clk,
	input wire logic rst,
	input wire ptd_accel_s accel,
	input wire ptd_mode_s mode,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic pulseIrq
);

	// Step exponent for the time limit, from filter, mode and data rate
	function automatic logic [3:0] stepShift(input logic lpf, input ptd_osmode_e os,
		input logic [2:0] odr);
		logic [31:0] tbl;
		tbl = `PTD_EXP_F0_NORMAL;
		unique case (os)
			OS_NORMAL: tbl = lpf ? `PTD_EXP_F1_NORMAL : `PTD_EXP_F0_NORMAL;
			OS_LOWNOISE: tbl = lpf ? `PTD_EXP_F1_LOWNOISE : `PTD_EXP_F0_LOWNOISE;
			OS_HIRES: tbl = lpf ? `PTD_EXP_F1_HIRES : `PTD_EXP_F0_HIRES;
			OS_LOWPOWER: tbl = lpf ? `PTD_EXP_F1_LOWPOWER : `PTD_EXP_F0_LOWPOWER;
		endcase
		return tbl[odr * `PTD_NIB_W +: `PTD_NIB_W];
	endfunction : stepShift

	// Threshold register index for an address, or none
	function automatic logic isThsAddr(input logic [7:0] a);
		return (a == `PTD_ADDR_THS_X) || (a == `PTD_ADDR_THS_Y) || (a == `PTD_ADDR_THS_Z);
	endfunction : isThsAddr

	function automatic logic [1:0] thsIndex(input logic [7:0] a);
		logic [7:0] d;
		d = a - `PTD_ADDR_THS_X;
		return d[1:0];
	endfunction : thsIndex

	logic [6:0] pulseThreshold [3];
	logic [7:0] pulseTimeLimit;
	logic [7:0] pulseLatency;
	logic [7:0] secondPulseWindow;
	logic [7:0] pulseEventSource;
	ptd_state_e state;
	ptd_state_e next_state;
	logic [16:0] baseCnt;
	logic baseTick;
	logic [9:0] preCnt;
	logic [7:0] stepCount;
	logic [9:0] limitLen;
	logic [9:0] stepLen;
	logic [2:0] over;
	logic [2:0] neg;
	logic [2:0] trigAxes;
	logic [2:0] trigPol;
	logic [2:0] next_trigAxes;
	logic [2:0] next_trigPol;
	logic released;
	logic restart;
	logic eventSet;
	logic eventDouble;
	logic srcRead;

	// Per-axis magnitude compare against its own capped threshold
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : gAxis
			logic [7:0] raw;
			logic [7:0] mag;
			logic [6:0] effTh;
			assign raw = accel.axis[g];
			assign neg[g] = raw[`PTD_SIGN_BIT];
			assign mag = neg[g] ? 8'(~raw + 8'h01) : raw;
			assign effTh = (mode.lowNoise && pulseThreshold[g] > `PTD_THS_CAP_LN)
				? `PTD_THS_CAP_LN : pulseThreshold[g];
			assign over[g] = (pulseThreshold[g] != `PTD_THS_OFF)
				&& (mag > {1'b0, effTh});
		end
	endgenerate

	// Step sizes: latency and window steps are twice the time-limit step
	assign limitLen = `PTD_STEP_ONE << stepShift(mode.pulseLowpassEnable, mode.osMode,
		mode.dataRate);
	assign stepLen = (state == ST_LATENCY || state == ST_WINDOW)
		? (limitLen << 1) : limitLen;

	assign released = (over & trigAxes) == 3'h0;
	assign restart = next_state != state;
	assign srcRead = regRead && (regAddr == `PTD_ADDR_SRC);

	// Base 0.625 ms tick divider
	always_ff @(posedge clk)
	begin
		if (rst || baseCnt == 17'(BASE_CYCLES - 1))
			baseCnt <= '0;
		else
			baseCnt <= baseCnt + 17'h00001;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			baseTick <= 1'b0;
		else
			baseTick <= baseCnt == 17'(BASE_CYCLES - 1);
	end

	// Step prescaler and saturating step counter, restarted per interval
	always_ff @(posedge clk)
	begin
		if (rst || restart)
		begin
			preCnt <= '0;
			stepCount <= `PTD_CNT_ZERO;
		end
		else if (baseTick)
		begin
			if (preCnt == stepLen - 10'h001)
			begin
				preCnt <= '0;
				if (stepCount != `PTD_STEP_MAX)
					stepCount <= stepCount + 8'h01;
			end
			else
				preCnt <= preCnt + 10'h001;
		end
	end

	// Next state and event decision
	always_comb
	begin
		next_state = state;
		next_trigAxes = trigAxes;
		next_trigPol = trigPol;
		eventSet = 1'b0;
		eventDouble = 1'b0;
		unique case (state)
			ST_IDLE:
				if (|over)
				begin
					next_state = ST_FIRST;
					next_trigAxes = over;
					next_trigPol = neg & over;
				end
			ST_FIRST:
				if (stepCount >= pulseTimeLimit)
					next_state = ST_RELEASE;
				else if (released)
				begin
					next_state = ST_LATENCY;
					eventSet = mode.singleEnable;
				end
			ST_LATENCY:
				if (stepCount >= pulseLatency)
				begin
					if (mode.doubleEnable)
						next_state = ST_WINDOW;
					else
						next_state = (|over) ? ST_RELEASE : ST_IDLE;
				end
			ST_WINDOW:
				if (|over)
				begin
					next_state = ST_SECOND;
					next_trigAxes = over;
					next_trigPol = neg & over;
				end
				else if (stepCount >= secondPulseWindow)
					next_state = ST_IDLE;
			ST_SECOND:
				if (stepCount >= pulseTimeLimit)
					next_state = ST_RELEASE;
				else if (released)
				begin
					next_state = ST_IDLE;
					eventSet = 1'b1;
					eventDouble = 1'b1;
				end
			ST_RELEASE:
				if (!(|over))
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	// Detector state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			trigAxes <= 3'h0;
			trigPol <= 3'h0;
		end
		else
		begin
			state <= next_state;
			trigAxes <= next_trigAxes;
			trigPol <= next_trigPol;
		end
	end

	// Event source: frozen once active, cleared on read, a new event wins
	always_ff @(posedge clk)
	begin
		if (rst)
			pulseEventSource <= `PTD_RST_SRC;
		else if (eventSet && (!pulseEventSource[`PTD_SRC_ACTIVE] || srcRead))
		begin
			pulseEventSource <= `PTD_RST_SRC;
			pulseEventSource[`PTD_SRC_ACTIVE] <= 1'b1;
			pulseEventSource[`PTD_SRC_AX_LSB +: 3] <= trigAxes;
			pulseEventSource[`PTD_SRC_DOUBLE] <= eventDouble;
			pulseEventSource[`PTD_SRC_POL_LSB +: 3] <= trigPol;
		end
		else if (srcRead)
			pulseEventSource <= `PTD_RST_SRC;
	end

	// Interrupt mirrors the active flag
	always_ff @(posedge clk)
	begin
		if (rst)
			pulseIrq <= 1'b0;
		else if (eventSet && (!pulseEventSource[`PTD_SRC_ACTIVE] || srcRead))
			pulseIrq <= 1'b1;
		else if (srcRead)
			pulseIrq <= 1'b0;
	end

	// Threshold registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pulseThreshold[0] <= `PTD_RST_THS;
			pulseThreshold[1] <= `PTD_RST_THS;
			pulseThreshold[2] <= `PTD_RST_THS;
		end
		else if (regWrite && isThsAddr(regAddr))
			pulseThreshold[thsIndex(regAddr)] <= regWrData[6:0];
	end

	// Timing registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pulseTimeLimit <= `PTD_RST_TIME_LIMIT;
			pulseLatency <= `PTD_RST_LATENCY;
			secondPulseWindow <= `PTD_RST_WINDOW;
		end
		else if (regWrite)
		begin
			if (regAddr == `PTD_ADDR_TIME_LIMIT)
				pulseTimeLimit <= regWrData;
			if (regAddr == `PTD_ADDR_LATENCY)
				pulseLatency <= regWrData;
			if (regAddr == `PTD_ADDR_WINDOW)
				secondPulseWindow <= regWrData;
		end
	end

	// Registered read data; unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (rst)
			regRdData <= 8'h00;
		else if (regRead)
		begin
			if (isThsAddr(regAddr))
				regRdData <= {1'b0, pulseThreshold[thsIndex(regAddr)]};
			else if (regAddr == `PTD_ADDR_SRC)
				regRdData <= pulseEventSource;
			else if (regAddr == `PTD_ADDR_TIME_LIMIT)
				regRdData <= pulseTimeLimit;
			else if (regAddr == `PTD_ADDR_LATENCY)
				regRdData <= pulseLatency;
			else if (regAddr == `PTD_ADDR_WINDOW)
				regRdData <= secondPulseWindow;
			else
				regRdData <= 8'h00;
		end
	end

endmodule : ptd_pulse_timing
`default_nettype wire

// *** ptd_pulse_timing_properties.sv ***
// Port assertions for the pulse timing detector.
// Assumes a bind onto ptd_pulse_timing, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ptd_pulse_timing_properties
	import ptd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire ptd_accel_s accel,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic pulseIrq
);
	logic [3:0] quietCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Cycles since any axis was nonzero
	always_ff @(posedge clk)
		if (rst || accel != '0)
			quietCnt <= 4'h0;
		else if (quietCnt != 4'hF)
			quietCnt <= quietCnt + 4'h1;
	property p_rstClear; $fell(rst) |-> regRdData == 8'h00 && !pulseIrq; endproperty
	a_rstClear: assert property (p_rstClear) else $error("reset state wrong");
	property p_srcRead; regRead && regAddr == 8'h22 && pulseIrq |=> regRdData[7]; endproperty
	a_srcRead: assert property (p_srcRead) else $error("source lost flag");
	property p_irqHold; pulseIrq && !(regRead && regAddr == 8'h22) |=> pulseIrq; endproperty
	a_irqHold: assert property (p_irqHold) else $error("irq dropped unread");
	property p_thsBit7; regRead && regAddr inside {[8'h23:8'h25]} |=> !regRdData[7]; endproperty
	a_thsBit7: assert property (p_thsBit7) else $error("threshold bit 7 set");
	property p_unmapped;
		regRead && !(regAddr inside {[8'h22:8'h28]}) |=> regRdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rdHold; !regRead |=> $stable(regRdData); endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved");
	property p_echo;
		regWrite && regAddr inside {[8'h26:8'h28]} ##1 !regWrite
		##1 regRead && !regWrite && regAddr == $past(regAddr, 2)
		|=> regRdData == $past(regWrData, 3);
	endproperty
	a_echo: assert property (p_echo) else $error("timer register echo wrong");
	property p_quiet; $rose(pulseIrq) |-> quietCnt < 4'h8; endproperty
	a_quiet: assert property (p_quiet) else $error("event without pulse");
	c_event: cover property ($rose(pulseIrq));
	c_srcRead: cover property (regRead && regAddr == 8'h22 && pulseIrq);
	c_latency: cover property (regWrite && regAddr == 8'h27);
endmodule : ptd_pulse_timing_properties
bind ptd_pulse_timing ptd_pulse_timing_properties i_ptd_pulse_timing_properties (.clk(clk),
	.rst(rst), .accel(accel), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
	.regWrData(regWrData), .regRdData(regRdData), .pulseIrq(pulseIrq));
`default_nettype wire

// *** ptd_regs.svh ***
// Register offsets, field positions, reset values and timing constants
// for the pulse timing detector. Definitions only; included by bare name.
`ifndef PTD_REGS_SVH
`define PTD_REGS_SVH

// Register offsets
`define PTD_ADDR_SRC 8'h22
`define PTD_ADDR_THS_X 8'h23
`define PTD_ADDR_THS_Y 8'h24
`define PTD_ADDR_THS_Z 8'h25
`define PTD_ADDR_TIME_LIMIT 8'h26
`define PTD_ADDR_LATENCY 8'h27
`define PTD_ADDR_WINDOW 8'h28

// Reset values
`define PTD_RST_THS 7'h00
`define PTD_RST_TIME_LIMIT 8'h00
`define PTD_RST_LATENCY 8'h00
`define PTD_RST_WINDOW 8'h00
`define PTD_RST_SRC 8'h00

// Event source register field positions
`define PTD_SRC_ACTIVE 7
`define PTD_SRC_AX_LSB 4
`define PTD_SRC_DOUBLE 3
`define PTD_SRC_POL_LSB 0

// Threshold: 0.063 g per code over a fixed 8 g range; 4 g cap under low noise
`define PTD_THS_CAP_LN 7'h3F
`define PTD_THS_OFF 7'h00
`define PTD_SIGN_BIT 7

// Base time unit 0.625 ms at a 10 ns clock
`define PTD_BASE_STEP_NS 625000
`define PTD_CLK_NS 10

// Time-limit step exponents (base units = 2**exp), one nibble per data-rate code
`define PTD_NIB_W 4
`define PTD_EXP_F0_NORMAL 32'h33332100
`define PTD_EXP_F0_LOWNOISE 32'h55532100
`define PTD_EXP_F0_HIRES 32'h00000000
`define PTD_EXP_F0_LOWPOWER 32'h66643210
`define PTD_EXP_F1_NORMAL 32'h55554321
`define PTD_EXP_F1_LOWNOISE 32'h77754321
`define PTD_EXP_F1_HIRES 32'h22222221
`define PTD_EXP_F1_LOWPOWER 32'h88754321

// Step count limits
`define PTD_STEP_MAX 8'hFF
`define PTD_STEP_ONE 10'h001
`define PTD_CNT_ZERO 8'h00

`endif

// *** tb.sv ***
// Self-checking bench for the pulse timing detector.
// Assumes a base tick of 4 clocks so intervals stay short.
`timescale 1ns/1ps
`default_nettype none
module tb import ptd_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ptd_accel_s accel = '0;
	ptd_mode_s mode = '0;
	logic regWrite, regRead, pulseIrq;
	logic [7:0] regAddr, regWrData, regRdData, d, v;
	int failures = 0;
	int compares = 0;
	int s;
	ptd_host_model i_ptd_host_model (.clk(clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
	ptd_pulse_timing #(.BASE_CYCLES(4)) i_ptd_pulse_timing (.clk(clk), .rst(rst),
		.accel(accel), .mode(mode), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .pulseIrq(pulseIrq));
	// Clock
	always #5 clk = ~clk;
	// Compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Expected source byte
	function automatic logic [7:0] expSrc(input int ax, input logic neg, input logic dbl);
		return 8'h80 | (8'h10 << ax) | (8'(neg) << ax) | (8'(dbl) << 3);
	endfunction : expSrc
	// Expected time-limit step in base ticks of 4 clocks for filter, mode and rate
	function automatic int stepTicks(input logic lpf, input ptd_osmode_e os, input int odr);
		int t [8];
		t = '{default: 1};
		case ({lpf, os})
			{1'b1, OS_NORMAL}: t = '{2, 4, 8, 16, 32, 32, 32, 32};
			{1'b1, OS_LOWNOISE}: t = '{2, 4, 8, 16, 32, 128, 128, 128};
			{1'b1, OS_HIRES}: t = '{2, 4, 4, 4, 4, 4, 4, 4};
			{1'b1, OS_LOWPOWER}: t = '{2, 4, 8, 16, 32, 128, 256, 256};
			{1'b0, OS_NORMAL}: t = '{1, 1, 2, 4, 8, 8, 8, 8};
			{1'b0, OS_LOWNOISE}: t = '{1, 1, 2, 4, 8, 32, 32, 32};
			{1'b0, OS_LOWPOWER}: t = '{1, 2, 4, 8, 16, 64, 64, 64};
			default: t = '{default: 1};
		endcase
		return t[odr];
	endfunction : stepTicks
	// Read and compare
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		i_ptd_host_model.rd(a, d);
		chk(d, e);
	endtask : rdChk
	// Hold one axis at amp for len cycles
	task automatic tap(input int ax, input logic [7:0] amp, input int len);
		@(posedge clk) #1;
		accel.axis[ax] = amp;
		repeat (len) @(posedge clk);
		#1 accel = '0;
		repeat (8) @(posedge clk);
		#1;
	endtask : tap
	// Verdict
	task automatic final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	// Watchdog
	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		final_report;
	end
	// Tests
	initial
	begin
		void'($urandom(48));
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		for (int a = 8'h22; a <= 8'h30; a++)
			rdChk(8'(a), 8'h00);
		for (int a = 8'h23; a <= 8'h28; a++)
		begin
			v = 8'($urandom) | 8'h80;
			i_ptd_host_model.wr(8'(a), v);
			rdChk(8'(a), (a < 8'h26) ? (v & 8'h7F) : v);
		end
		i_ptd_host_model.wr(8'h22, 8'hFF);
		rdChk(8'h22, 8'h00);
		$display("test registers done");
		for (int a = 8'h23; a <= 8'h25; a++)
			i_ptd_host_model.wr(8'(a), 8'h0A);
		i_ptd_host_model.wr(8'h26, 8'h14);
		i_ptd_host_model.wr(8'h27, 8'h02);
		i_ptd_host_model.wr(8'h28, 8'h32);
		mode.osMode = ptd_osmode_e'($urandom_range(3));
		mode.pulseLowpassEnable = 1'($urandom);
		mode.singleEnable = 1'b1;
		for (int ax = 0; ax < 3; ax++)
		begin
			v = 8'($urandom_range(1));
			tap(ax, v[0] ? 8'hEC : 8'h14, 10);
			chk({7'h0, pulseIrq}, 8'h01);
			rdChk(8'h22, expSrc(ax, v[0], 1'b0));
			chk({7'h0, pulseIrq}, 8'h00);
			repeat (60) @(posedge clk);
		end
		tap(0, 8'h14, 400);
		rdChk(8'h22, 8'h00);
		tap(1, 8'h0A, 10);
		rdChk(8'h22, 8'h00);
		$display("test single done");
		i_ptd_host_model.wr(8'h25, 8'h64);
		mode.lowNoise = 1'b1;
		tap(2, 8'h46, 10);
		rdChk(8'h22, expSrc(2, 1'b0, 1'b0));
		repeat (60) @(posedge clk);
		#1 mode.lowNoise = 1'b0;
		tap(2, 8'h46, 10);
		rdChk(8'h22, 8'h00);
		$display("test low noise done");
		mode.singleEnable = 1'b0;
		mode.doubleEnable = 1'b1;
		tap(0, 8'h14, 10);
		repeat (60) @(posedge clk);
		tap(0, 8'h14, 10);
		rdChk(8'h22, expSrc(0, 1'b0, 1'b1));
		tap(0, 8'h14, 10);
		repeat (1000) @(posedge clk);
		tap(0, 8'h14, 10);
		rdChk(8'h22, 8'h00);
		repeat (1000) @(posedge clk);
		$display("test double done");
		// Step sizes at a random rate, mode and filter setting
		#1 mode.doubleEnable = 1'b0;
		mode.singleEnable = 1'b1;
		mode.dataRate = 3'($urandom_range(7));
		mode.osMode = ptd_osmode_e'($urandom_range(3));
		mode.pulseLowpassEnable = 1'($urandom);
		s = stepTicks(mode.pulseLowpassEnable, mode.osMode, int'(mode.dataRate));
		i_ptd_host_model.wr(8'h26, 8'h02);
		i_ptd_host_model.wr(8'h27, 8'h01);
		tap(0, 8'h14, 8 * s - 3);
		rdChk(8'h22, expSrc(0, 1'b0, 1'b0));
		repeat (8 * s + 8) @(posedge clk);
		tap(0, 8'h14, 8 * s + 1);
		rdChk(8'h22, 8'h00);
		i_ptd_host_model.wr(8'h27, 8'h08);
		tap(0, 8'h14, 3);
		rdChk(8'h22, expSrc(0, 1'b0, 1'b0));
		repeat (64 * s - 16) @(posedge clk);
		tap(0, 8'h14, 3);
		rdChk(8'h22, 8'h00);
		tap(0, 8'h14, 3);
		rdChk(8'h22, expSrc(0, 1'b0, 1'b0));
		$display("test timing done");
		final_report;
	end
endmodule : tb
`default_nettype wire
